// *** rtl/psc_decoder.sv ***
// front panel switch decoder: node, serial, hold, enable gating, offset trim
`timescale 1ns/10ps
module psc_decoder #(
   parameter int unsigned SWITCH_PERIOD = psc_pkg::SWITCH_PERIOD_CYC,
   parameter int unsigned ENABLE_PERIOD = psc_pkg::ENABLE_PERIOD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [9:0] front_switch_block_i,
   input wire logic enable_input_i,
   input wire logic [15:0] demand_analog_input_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic [3:0] node_number_o,
   output logic serial_rs485_o,
   output logic factory_restore_o,
   output logic autorun_suppress_o,
   output logic hold_o,
   output logic drive_enable_o,
   output logic [15:0] demand_offset_o,
   output logic [15:0] demand_corrected_o
);
   logic sw_tick;
   logic en_tick;

   psc_tick #(.PERIOD(SWITCH_PERIOD)) u_sw_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_o(sw_tick)
   );

   psc_tick #(.PERIOD(ENABLE_PERIOD)) u_en_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_o(en_tick)
   );

   // ---- startup latch group
   logic started_q, started_d;
   logic [3:0] node_q, node_d;
   logic rs485_q, rs485_d;
   logic restore_q, restore_d;
   logic noauto_q, noauto_d;
   logic [3:0] sw_node;
   logic [3:0] soft_node_q, soft_node_d;

   // bit order reversed so that switch 1 carries the weight of 8
   assign sw_node = {<<{front_switch_block_i[psc_pkg::SW_NODE_HI:psc_pkg::SW_NODE_LO]}};

   always_comb begin
      started_d = 1'b1;
      node_d = node_q;
      rs485_d = rs485_q;
      restore_d = restore_q;
      noauto_d = noauto_q;
      if (!started_q) begin
         // combinations read once on the first edge after reset release
         restore_d = (sw_node == psc_pkg::NODE_SW_ALL)
                   && !front_switch_block_i[psc_pkg::SW_ENABLE];
         noauto_d = front_switch_block_i[psc_pkg::SW_HOLD]
                  && front_switch_block_i[psc_pkg::SW_KEYPAD]
                  && !front_switch_block_i[psc_pkg::SW_ENABLE];
         rs485_d = front_switch_block_i[psc_pkg::SW_SERIAL];
         if (restore_d) begin
            // a factory restore wipes the address rather than latching one
            node_d = psc_pkg::NODE_RESET;
         end else if (sw_node == psc_pkg::NODE_SW_NONE || sw_node == psc_pkg::NODE_SW_ALL) begin
            node_d = soft_node_q;
         end else begin
            node_d = sw_node;
         end
      end else if (restore_q) begin
         node_d = psc_pkg::NODE_RESET;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         started_q <= 1'b0;
         node_q <= psc_pkg::NODE_RESET;
         rs485_q <= 1'b0;
         restore_q <= 1'b0;
         noauto_q <= 1'b0;
      end else begin
         started_q <= started_d;
         node_q <= node_d;
         rs485_q <= rs485_d;
         restore_q <= restore_d;
         noauto_q <= noauto_d;
      end
   end

   // ---- sampled switch group (switch 9 feeds only the startup check)
   logic hold_q, hold_d;
   logic sw8_q, sw8_d;
   logic sw8_prev_q, sw8_prev_d;
   logic sw7_q, sw7_d;
   logic sw8_rise_q, sw8_rise_d;
   logic tune_req_q, tune_req_d;

   always_comb begin
      hold_d = hold_q;
      sw8_d = sw8_q;
      sw8_prev_d = sw8_prev_q;
      sw7_d = sw7_q;
      sw8_rise_d = 1'b0;
      tune_req_d = 1'b0;
      if (sw_tick) begin
         hold_d = front_switch_block_i[psc_pkg::SW_HOLD];
         sw7_d = front_switch_block_i[psc_pkg::SW_TUNE];
         sw8_d = front_switch_block_i[psc_pkg::SW_ENABLE];
         sw8_prev_d = sw8_q;
         sw8_rise_d = front_switch_block_i[psc_pkg::SW_ENABLE] && !sw8_q;
         tune_req_d = sw8_q && !front_switch_block_i[psc_pkg::SW_ENABLE]
                    && front_switch_block_i[psc_pkg::SW_TUNE];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_q <= 1'b0;
         sw8_q <= 1'b0;
         sw8_prev_q <= 1'b0;
         sw7_q <= 1'b0;
         sw8_rise_q <= 1'b0;
         tune_req_q <= 1'b0;
      end else begin
         hold_q <= hold_d;
         sw8_q <= sw8_d;
         sw8_prev_q <= sw8_prev_d;
         sw7_q <= sw7_d;
         sw8_rise_q <= sw8_rise_d;
         tune_req_q <= tune_req_d;
      end
   end

   // ---- enable input and drive enable group
   logic ein_q, ein_d;
   logic ein_rise_q, ein_rise_d;
   logic ein_fall_q, ein_fall_d;
   logic armed_q, armed_d;
   logic cmd_q, cmd_d;
   logic en_q, en_d;
   logic combined_q, combined_d;
   logic wr_en_cmd, wr_dis_cmd;

   always_comb begin
      ein_d = ein_q;
      ein_rise_d = 1'b0;
      ein_fall_d = 1'b0;
      if (en_tick) begin
         ein_d = enable_input_i;
         ein_rise_d = enable_input_i && !ein_q;
         ein_fall_d = !enable_input_i && ein_q;
      end
      armed_d = armed_q;
      if (ein_rise_q) begin
         armed_d = 1'b1;
      end else if (ein_fall_q || !ein_q) begin
         armed_d = 1'b0;
      end
      cmd_d = cmd_q;
      if (wr_dis_cmd || ein_fall_q || !sw8_q) begin
         cmd_d = 1'b0;
      end
      if (wr_en_cmd) begin
         cmd_d = 1'b1;
      end
      if (combined_q && ((sw8_rise_q && ein_q) || (ein_rise_q && sw8_q))) begin
         cmd_d = 1'b1;
      end
      en_d = sw8_q && armed_q && ein_q && cmd_q && !restore_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ein_q <= 1'b0;
         ein_rise_q <= 1'b0;
         ein_fall_q <= 1'b0;
         armed_q <= 1'b0;
         cmd_q <= 1'b0;
         en_q <= 1'b0;
      end else begin
         ein_q <= ein_d;
         ein_rise_q <= ein_rise_d;
         ein_fall_q <= ein_fall_d;
         armed_q <= armed_d;
         cmd_q <= cmd_d;
         en_q <= en_d;
      end
   end

   // ---- offset trim group
   psc_pkg::psc_trim_e trim_q, trim_d;
   logic [15:0] offset_q, offset_d;
   logic [15:0] corr_q, corr_d;
   logic wr_trim_cmd, wr_defaults_cmd;

   always_comb begin
      trim_d = trim_q;
      offset_d = offset_q;
      case (trim_q)
         psc_pkg::PSC_TRIM_IDLE: begin
            if (tune_req_q || wr_trim_cmd) begin
               trim_d = psc_pkg::PSC_TRIM_MEAS;
            end
         end
         psc_pkg::PSC_TRIM_MEAS: begin
            offset_d = demand_analog_input_i;
            trim_d = psc_pkg::PSC_TRIM_DONE;
         end
         psc_pkg::PSC_TRIM_DONE: begin
            trim_d = psc_pkg::PSC_TRIM_IDLE;
         end
         default: begin
            trim_d = psc_pkg::PSC_TRIM_IDLE;
         end
      endcase
      if (wr_defaults_cmd || restore_q) begin
         offset_d = psc_pkg::TRIM_RESET;
      end
      corr_d = demand_analog_input_i - offset_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trim_q <= psc_pkg::PSC_TRIM_IDLE;
         offset_q <= psc_pkg::TRIM_RESET;
         corr_q <= psc_pkg::TRIM_RESET;
      end else begin
         trim_q <= trim_d;
         offset_q <= offset_d;
         corr_q <= corr_d;
      end
   end

   // ---- wishbone slave group
   logic ack_q, ack_d;
   logic err_q, err_d;
   logic [31:0] rdat_q, rdat_d;
   logic req;
   logic [3:0] adr;

   assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
   assign adr = wb_adr_i[3:0];
   assign wr_en_cmd = req && wb_we_i && wb_sel_i[0] && adr == psc_pkg::REG_CTRL
                    && wb_dat_i[psc_pkg::CTRL_EN_CMD];
   assign wr_dis_cmd = req && wb_we_i && wb_sel_i[0] && adr == psc_pkg::REG_CTRL
                     && wb_dat_i[psc_pkg::CTRL_DISABLE_CMD];
   assign wr_trim_cmd = req && wb_we_i && wb_sel_i[0] && adr == psc_pkg::REG_CTRL
                      && wb_dat_i[psc_pkg::CTRL_TRIM_CMD];
   assign wr_defaults_cmd = req && wb_we_i && wb_sel_i[0] && adr == psc_pkg::REG_CTRL
                          && wb_dat_i[psc_pkg::CTRL_DEFAULTS_CMD];

   always_comb begin
      ack_d = 1'b0;
      err_d = 1'b0;
      rdat_d = rdat_q;
      combined_d = combined_q;
      soft_node_d = soft_node_q;
      if (restore_q) begin
         combined_d = 1'b0;
         soft_node_d = psc_pkg::NODE_RESET;
      end
      if (req) begin
         rdat_d = 32'h0000_0000;
         if (adr == psc_pkg::REG_CTRL) begin
            ack_d = 1'b1;
            rdat_d[psc_pkg::CTRL_COMBINED] = combined_q;
            if (wb_we_i && wb_sel_i[0]) begin
               combined_d = wb_dat_i[psc_pkg::CTRL_COMBINED];
               if (wb_dat_i[psc_pkg::CTRL_DEFAULTS_CMD]) begin
                  combined_d = 1'b0;
               end
            end
         end else if (adr == psc_pkg::REG_STATUS) begin
            ack_d = 1'b1;
            rdat_d[10:0] = {trim_q != psc_pkg::PSC_TRIM_IDLE, cmd_q, en_q, ein_q,
                            noauto_q, restore_q, rs485_q, sw7_q, sw8_q, hold_q, armed_q};
         end else if (adr == psc_pkg::REG_NODE) begin
            ack_d = 1'b1;
            rdat_d[7:0] = {soft_node_q, node_q};
            if (wb_we_i && wb_sel_i[0]) begin
               soft_node_d = wb_dat_i[7:4];
            end
         end else if (adr == psc_pkg::REG_TRIM) begin
            ack_d = 1'b1;
            rdat_d[15:0] = offset_q;
         end else begin
            err_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
         combined_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         err_q <= err_d;
         rdat_q <= rdat_d;
         combined_q <= combined_d;
      end
   end

   // software node value survives a processor reset, cleared only by switch restore
   always_ff @(posedge clk_i) begin
      soft_node_q <= soft_node_d;
   end

   assign wb_dat_o = rdat_q;
   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
   assign node_number_o = node_q;
   assign serial_rs485_o = rs485_q;
   assign factory_restore_o = restore_q;
   assign autorun_suppress_o = noauto_q;
   assign hold_o = hold_q;
   assign drive_enable_o = en_q;
   assign demand_offset_o = offset_q;
   assign demand_corrected_o = corr_q;
endmodule

// *** rtl/psc_pkg.sv ***
// package of constants for the front panel switch configuration decoder
package psc_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned SWITCH_PERIOD_MS = 100;
   localparam int unsigned ENABLE_PERIOD_MS = 1;
   localparam int unsigned SWITCH_PERIOD_CYC = CLK_HZ / 1000 * SWITCH_PERIOD_MS;
   localparam int unsigned ENABLE_PERIOD_CYC = CLK_HZ / 1000 * ENABLE_PERIOD_MS;
   // switch block bit positions, switch n at bit n-1
   localparam int unsigned SW_NODE_LO = 0;
   localparam int unsigned SW_NODE_HI = 3;
   localparam int unsigned SW_HOLD = 4;
   localparam int unsigned SW_TUNE = 6;
   localparam int unsigned SW_ENABLE = 7;
   localparam int unsigned SW_KEYPAD = 8;
   localparam int unsigned SW_SERIAL = 9;
   localparam logic [3:0] NODE_SW_NONE = 4'h0;
   localparam logic [3:0] NODE_SW_ALL = 4'hf;
   localparam logic [3:0] NODE_RESET = 4'h0;
   localparam logic [15:0] TRIM_RESET = 16'h0000;
   // wishbone register byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_NODE = 4'h8;
   localparam logic [3:0] REG_TRIM = 4'hc;
   // control register bits
   localparam int unsigned CTRL_EN_CMD = 0;
   localparam int unsigned CTRL_COMBINED = 1;
   localparam int unsigned CTRL_TRIM_CMD = 2;
   localparam int unsigned CTRL_DEFAULTS_CMD = 3;
   localparam int unsigned CTRL_DISABLE_CMD = 4;
   typedef enum logic [2:0] {
      PSC_TRIM_IDLE = 3'b001,
      PSC_TRIM_MEAS = 3'b010,
      PSC_TRIM_DONE = 3'b100
   } psc_trim_e;
endpackage

// *** rtl/psc_tick.sv ***
// free running period tick generator
`timescale 1ns/10ps
module psc_tick #(
   parameter int unsigned PERIOD = 125_000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   output logic tick_o
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic tick_d;
   logic tick_q;

   always_comb begin
      tick_d = 1'b0;
      cnt_d = cnt_q + 32'h0000_0001;
      if (cnt_q == 32'(PERIOD - 1)) begin
         cnt_d = 32'h0000_0000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick_o = tick_q;
endmodule

// *** verification/psc_decoder_sva.sv ***
// assertion checker for the switch decoder
`timescale 1ns/10ps
module psc_decoder_sva #(
   parameter int unsigned SWITCH_PERIOD = 20,
   parameter int unsigned ENABLE_PERIOD = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [9:0] front_switch_block_i,
   input wire logic enable_input_i,
   input wire logic [3:0] node_number_o,
   input wire logic serial_rs485_o,
   input wire logic factory_restore_o,
   input wire logic autorun_suppress_o,
   input wire logic hold_o,
   input wire logic drive_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [1:0] up_q, up_d;
   logic [31:0] en_q, en_d, s8_q, s8_d, hc_q, hc_d;
   logic h_q, h_d;
   logic [3:0] nsw;
   logic [9:0] sw;
   assign sw = front_switch_block_i;
   assign nsw = {sw[0], sw[1], sw[2], sw[3]};
   always_comb begin
      up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
      en_d = enable_input_i ? 32'h0000_0000 : en_q + 32'h0000_0001;
      s8_d = sw[7] ? 32'h0000_0000 : s8_q + 32'h0000_0001;
      hc_d = (hold_o != h_q) ? 32'h0000_0000 : hc_q + 32'h0000_0001;
      h_d = hold_o;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         up_q <= 2'h0;
         en_q <= 32'h0000_0000;
         s8_q <= 32'h0000_0000;
         hc_q <= 32'h0000_0000;
         h_q <= 1'b0;
      end else begin
         up_q <= up_d;
         en_q <= en_d;
         s8_q <= s8_d;
         hc_q <= hc_d;
         h_q <= h_d;
      end
   end
   property p_node;
      $fell(rst_i) && nsw != 4'h0 && nsw != 4'hf |=> node_number_o == $past(nsw);
   endproperty
   a_node: assert property (p_node) else $error("node number not from switches");
   property p_restore;
      $fell(rst_i) |=> factory_restore_o == ($past(nsw) == 4'hf && !$past(sw[7]));
   endproperty
   a_restore: assert property (p_restore) else $error("factory restore wrong");
   property p_autorun;
      $fell(rst_i) |=> autorun_suppress_o == ($past(sw[4]) && $past(sw[8]) && !$past(sw[7]));
   endproperty
   a_autorun: assert property (p_autorun) else $error("autorun suppress wrong");
   property p_stable;
      up_q == 2'h3 |-> $stable({node_number_o, serial_rs485_o,
         factory_restore_o, autorun_suppress_o});
   endproperty
   a_stable: assert property (p_stable) else $error("latched setting changed");
   property p_rst_node;
      factory_restore_o |-> node_number_o == 4'h0 && !drive_enable_o;
   endproperty
   a_rst_node: assert property (p_rst_node) else $error("restore kept node");
   property p_en_gate;
      en_q > ENABLE_PERIOD + 4 |-> !drive_enable_o;
   endproperty
   a_en_gate: assert property (p_en_gate) else $error("enabled with input off");
   property p_sw8_gate;
      s8_q > SWITCH_PERIOD + 4 |-> !drive_enable_o;
   endproperty
   a_sw8_gate: assert property (p_sw8_gate) else $error("enabled with switch off");
   property p_hold;
      $changed(hold_o) |-> hc_q >= SWITCH_PERIOD / 2;
   endproperty
   a_hold: assert property (p_hold) else $error("hold sampled too often");
   c_en: cover property ($rose(drive_enable_o));
   c_rst: cover property ($fell(rst_i) ##1 factory_restore_o);
   c_hold: cover property ($changed(hold_o));
endmodule
bind psc_decoder psc_decoder_sva #(.SWITCH_PERIOD(SWITCH_PERIOD),
   .ENABLE_PERIOD(ENABLE_PERIOD)) u_psc_decoder_sva (.clk_i, .rst_i,
   .front_switch_block_i, .enable_input_i, .node_number_o, .serial_rs485_o,
   .factory_restore_o, .autorun_suppress_o, .hold_o, .drive_enable_o);

// *** verification/psc_decoder_tb.sv ***
// self-checking testbench for the switch decoder
`timescale 1ns/10ps
module psc_decoder_tb;
   localparam int unsigned SP = 20;
   localparam int unsigned EP = 4;
   logic clk_i, rst_i, enable_input_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
   logic serial_rs485_o, factory_restore_o, autorun_suppress_o, hold_o, drive_enable_o;
   logic [9:0] sw, front_switch_block_i;
   logic [15:0] demand_analog_input_i, demand_offset_o, demand_corrected_o;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
   logic [3:0] wb_sel_i, node_number_o, n;
   logic er;
   int n_errors = 0;
   int samples_checked = 0;
   psc_switch_model u_psc_switch_model (.clk_i, .set_i(sw), .front_switch_block_o(front_switch_block_i));
   psc_decoder #(.SWITCH_PERIOD(SP), .ENABLE_PERIOD(EP)) u_psc_decoder (.clk_i, .rst_i,
      .front_switch_block_i, .enable_input_i, .demand_analog_input_i, .wb_adr_i, .wb_dat_i,
      .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
      .node_number_o, .serial_rs485_o, .factory_restore_o, .autorun_suppress_o, .hold_o,
      .drive_enable_o, .demand_offset_o, .demand_corrected_o);
   task automatic stop_test;
      $display("compares %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {28'h000_0000, a};
      wb_dat_i <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         stop_test();
      end
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic power_up(input logic [9:0] s);
      sw <= s;
      rst_i <= 1'b1;
      cyc(3);
      rst_i <= 1'b0;
      cyc(3);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      cyc(100000);
      n_errors++;
      stop_test();
   end
   initial begin
      rst_i = 1'b1;
      sw = 10'h08c;
      enable_input_i = 1'b0;
      demand_analog_input_i = 16'h0000;
      {wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
      wb_adr_i = 32'h0000_0000;
      wb_dat_i = 32'h0000_0000;
      wb_sel_i = 4'hf;
      @(posedge clk_i);
      power_up(10'h08c);
      wb(1'b1, psc_pkg::REG_NODE, 32'h0000_0050);
      for (int k = 0; k < 16; k++) begin
         n = 4'(k);
         power_up({n[0], 5'h08, n[0], n[1], n[2], n[3]});
         chk(node_number_o, (n == 4'h0 || n == 4'hf) ? 4'h5 : n);
         chk(serial_rs485_o, n[0]);
      end
      power_up(10'h00f);
      chk(factory_restore_o, 1'b1);
      chk(node_number_o, 4'h0);
      power_up(10'h110);
      chk({autorun_suppress_o, factory_restore_o}, 2'h2);
      power_up(10'h08c);
      chk(node_number_o, 4'h3);
      cyc(SP);
      enable_input_i <= 1'b1;
      cyc(EP * 3);
      wb(1'b1, psc_pkg::REG_CTRL, 32'h0000_0001);
      cyc(4);
      chk(drive_enable_o, 1'b1);
      enable_input_i <= 1'b0;
      cyc(EP * 2);
      enable_input_i <= 1'b1;
      cyc(EP * 3);
      chk(drive_enable_o, 1'b0);
      wb(1'b1, psc_pkg::REG_CTRL, 32'h0000_0001);
      cyc(4);
      chk(drive_enable_o, 1'b1);
      sw[7] <= 1'b0;
      cyc(SP * 2);
      chk(drive_enable_o, 1'b0);
      wb(1'b1, psc_pkg::REG_CTRL, 32'h0000_0002);
      sw[7] <= 1'b1;
      cyc(SP * 2);
      chk(drive_enable_o, 1'b1);
      sw[4] <= 1'b1;
      cyc(SP * 2);
      chk(hold_o, 1'b1);
      sw[4] <= 1'b0;
      cyc(2);
      chk(hold_o, 1'b1);
      sw[4] <= 1'b1;
      sw[8] <= 1'b1;
      demand_analog_input_i <= 16'h0123;
      sw[6] <= 1'b1;
      cyc(SP * 2);
      sw[7] <= 1'b0;
      cyc(SP * 2);
      chk(demand_offset_o, 16'h0123);
      chk({node_number_o, autorun_suppress_o}, 5'h06);
      demand_analog_input_i <= 16'h0130;
      cyc(3);
      chk(demand_corrected_o, 16'h000d);
      wb(1'b1, psc_pkg::REG_CTRL, 32'h0000_0008);
      cyc(2);
      chk({node_number_o, demand_offset_o}, 20'h3_0000);
      sw[6] <= 1'b0;
      demand_analog_input_i <= 16'h0040;
      wb(1'b1, psc_pkg::REG_CTRL, 32'h0000_0004);
      cyc(4);
      wb(1'b0, psc_pkg::REG_TRIM, 32'h0000_0000);
      chk(rd[15:0], 16'h0040);
      wb_sel_i <= 4'h0;
      wb(1'b1, psc_pkg::REG_NODE, 32'h0000_0070);
      wb_sel_i <= 4'hf;
      wb(1'b0, psc_pkg::REG_NODE, 32'h0000_0000);
      chk(rd[7:0], 8'h03);
      wb(1'b0, 4'h2, 32'h0000_0000);
      chk(er, 1'b1);
      stop_test();
   end
endmodule

// *** verification/psc_switch_model.sv ***
// behavioural model of the ten-way front panel switch block
`timescale 1ns/10ps
module psc_switch_model (
   input wire logic clk_i,
   input wire logic [9:0] set_i,
   output logic [9:0] front_switch_block_o
);
   // contacts settle one clock after a lever is moved
   always_ff @(posedge clk_i) begin
      front_switch_block_o <= set_i;
   end
endmodule
